/* File: core/hwm_acc_if.sv */
`timescale 1ns/100ps
interface hwm_acc_if;
  logic wr;
  logic [7:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [6:0] slave_addr;

  modport serial (output wr, output idx, output wdata, input rdata, input slave_addr);
  modport regs (input wr, input idx, input wdata, output rdata, output slave_addr);
endinterface : hwm_acc_if

/* File: core/hwm_i2c_slave.sv */
`timescale 1ns/100ps
module hwm_i2c_slave
  import hwm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic scl_sync,
  input wire logic sda_sync,
  output logic sda_oe,
  hwm_acc_if.serial acc
);
  import hwm_pkg::*;

  hwm_i2c_state_t state_reg, state_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] idx_reg, idx_next;
  logic [7:0] wdata_reg, wdata_next;
  logic rw_reg, rw_next;
  logic ack_ok_reg, ack_ok_next;
  logic oe_reg, oe_next;
  logic wr_reg, wr_next;
  logic scl_prev_reg, sda_prev_reg;
  logic scl_rise, scl_fall, start_seen, stop_seen;

  assign scl_rise = scl_sync & ~scl_prev_reg;
  assign scl_fall = ~scl_sync & scl_prev_reg;
  assign start_seen = scl_sync & scl_prev_reg & sda_prev_reg & ~sda_sync;
  assign stop_seen = scl_sync & scl_prev_reg & ~sda_prev_reg & sda_sync;

  always_comb begin
    state_next = state_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    idx_next = idx_reg;
    wdata_next = wdata_reg;
    rw_next = rw_reg;
    ack_ok_next = ack_ok_reg;
    oe_next = oe_reg;
    wr_next = 1'b0;
    if (start_seen) begin
      state_next = I2C_ADDR;
      bit_next = 4'h0;
      oe_next = 1'b0;
    end else if (stop_seen) begin
      state_next = I2C_IDLE;
      oe_next = 1'b0;
    end else if (scl_rise) begin
      unique case (state_reg)
        I2C_ADDR, I2C_IDX, I2C_WDATA: begin
          shift_next = {shift_reg[6:0], sda_sync};
          bit_next = bit_reg + 4'h1;
        end
        I2C_TX_ACK: ack_ok_next = ~sda_sync;
        default: ;
      endcase
    end else if (scl_fall) begin
      unique case (state_reg)
        I2C_ADDR: begin
          if (bit_reg == BITS_PER_BYTE) begin
            if (shift_reg[7:1] == acc.slave_addr) begin
              rw_next = shift_reg[0];
              oe_next = 1'b1;
              state_next = I2C_ADDR_ACK;
            end else begin
              state_next = I2C_IDLE;
            end
          end
        end
        I2C_ADDR_ACK: begin
          bit_next = 4'h0;
          if (rw_reg) begin
            oe_next = ~acc.rdata[7];
            shift_next = {acc.rdata[6:0], 1'b0};
            bit_next = 4'h1;
            state_next = I2C_TX;
          end else begin
            oe_next = 1'b0;
            state_next = I2C_IDX;
          end
        end
        I2C_IDX: begin
          if (bit_reg == BITS_PER_BYTE) begin
            idx_next = shift_reg;
            oe_next = 1'b1;
            state_next = I2C_IDX_ACK;
          end
        end
        I2C_IDX_ACK: begin
          oe_next = 1'b0;
          bit_next = 4'h0;
          state_next = I2C_WDATA;
        end
        I2C_WDATA: begin
          if (bit_reg == BITS_PER_BYTE) begin
            wdata_next = shift_reg;
            wr_next = 1'b1;
            oe_next = 1'b1;
            state_next = I2C_WDATA_ACK;
          end
        end
        I2C_WDATA_ACK: begin
          oe_next = 1'b0;
          bit_next = 4'h0;
          state_next = I2C_WDATA;
        end
        I2C_TX: begin
          if (bit_reg == BITS_PER_BYTE) begin
            oe_next = 1'b0;
            state_next = I2C_TX_ACK;
          end else begin
            oe_next = ~shift_reg[7];
            shift_next = {shift_reg[6:0], 1'b0};
            bit_next = bit_reg + 4'h1;
          end
        end
        I2C_TX_ACK: begin
          if (ack_ok_reg) begin
            oe_next = ~acc.rdata[7];
            shift_next = {acc.rdata[6:0], 1'b0};
            bit_next = 4'h1;
            state_next = I2C_TX;
          end else begin
            state_next = I2C_IDLE;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= I2C_IDLE;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      idx_reg <= 8'h00;
      wdata_reg <= 8'h00;
      rw_reg <= 1'b0;
      ack_ok_reg <= 1'b0;
      oe_reg <= 1'b0;
      wr_reg <= 1'b0;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      idx_reg <= idx_next;
      wdata_reg <= wdata_next;
      rw_reg <= rw_next;
      ack_ok_reg <= ack_ok_next;
      oe_reg <= oe_next;
      wr_reg <= wr_next;
      scl_prev_reg <= scl_sync;
      sda_prev_reg <= sda_sync;
    end
  end

  assign sda_oe = oe_reg;
  assign acc.wr = wr_reg;
  assign acc.idx = idx_reg;
  assign acc.wdata = wdata_reg;
endmodule : hwm_i2c_slave

/* File: core/hwm_monitor_top.sv */
`timescale 1ns/100ps
// Behaviour
// - index port base+5h, data port base+6h
// - base 290h gives ports 295h and 296h
// - serial slave address held at serial_bus_slave_address
// - both paths reach the same registers
// - one 8-bit converter digitizes twelve inputs
// - voltage code is 8 mV per count
// - 3.3 V supplies read through halving divider
// - system 8-bit, cpu/aux 9-bit two's complement
// - system_temperature_reading returns system temperature
// - 9-bit: high byte 50h, lsb 51h bit7
// - out-of-range parameter raises warning output
module hwm_monitor_top
  import hwm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] monitor_base_high,
  input wire logic [7:0] monitor_base_low,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_ack,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic adc_start,
  output logic [3:0] adc_chan,
  output logic adc_halve,
  input wire logic adc_done,
  input wire logic [7:0] adc_data,
  input wire logic adc_lsb,
  output logic warning_out,
  output logic over_temperature_out
);
  import hwm_pkg::*;

  hwm_acc_if acc ();

  ////////////////////////////////////////////////////////////////////////////
  // serial pin synchronisers and slave engine
  logic scl_meta_reg, scl_sync_reg, sda_meta_reg, sda_sync_reg;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
    end else begin
      scl_meta_reg <= scl_in;
      scl_sync_reg <= scl_meta_reg;
      sda_meta_reg <= sda_in;
      sda_sync_reg <= sda_meta_reg;
    end
  end

  hwm_i2c_slave u_i2c (
    .ref_clk(ref_clk),
    .reset(reset),
    .scl_sync(scl_sync_reg),
    .sda_sync(sda_sync_reg),
    .sda_oe(sda_oe),
    .acc(acc)
  );

  // open drain: only ever pulls low
  assign sda_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer and value store
  hwm_seq_t seq_reg, seq_next;
  logic [3:0] chan_reg, chan_next;
  logic start_reg, start_next;
  logic halve_reg, halve_next;
  logic [7:0] reading_reg [NUM_CH];
  logic [7:0] reading_next [NUM_CH];
  logic cpu_lsb_reg, cpu_lsb_next, aux_lsb_reg, aux_lsb_next;

  always_comb begin
    seq_next = seq_reg;
    chan_next = chan_reg;
    start_next = 1'b0;
    reading_next = reading_reg;
    cpu_lsb_next = cpu_lsb_reg;
    aux_lsb_next = aux_lsb_reg;
    unique case (seq_reg)
      SEQ_START: begin
        start_next = 1'b1;
        seq_next = SEQ_WAIT;
      end
      SEQ_WAIT: begin
        if (adc_done) begin
          reading_next[chan_reg] = adc_data;
          if (chan_reg == CH_CPU_TEMP) begin
            cpu_lsb_next = adc_lsb;
          end
          if (chan_reg == CH_AUX_TEMP) begin
            aux_lsb_next = adc_lsb;
          end
          chan_next = (chan_reg == LAST_CH) ? 4'h0 : chan_reg + 4'h1;
          seq_next = SEQ_START;
        end
      end
    endcase
    halve_next = HALVE_MASK[chan_next];
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      seq_reg <= SEQ_START;
      chan_reg <= 4'h0;
      start_reg <= 1'b0;
      halve_reg <= HALVE_MASK[0];
      cpu_lsb_reg <= 1'b0;
      aux_lsb_reg <= 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
        reading_reg[i] <= 8'h00;
      end
    end else begin
      seq_reg <= seq_next;
      chan_reg <= chan_next;
      start_reg <= start_next;
      halve_reg <= halve_next;
      cpu_lsb_reg <= cpu_lsb_next;
      aux_lsb_reg <= aux_lsb_next;
      reading_reg <= reading_next;
    end
  end

  assign adc_start = start_reg;
  assign adc_chan = chan_reg;
  assign adc_halve = halve_reg;

  ////////////////////////////////////////////////////////////////////////////
  // port decode and register access
  logic [15:0] base;
  logic idx_hit, data_hit;
  logic [7:0] lpc_index_reg, lpc_index_next;
  logic [7:0] io_rdata_reg, io_rdata_next;
  logic io_ack_reg, io_ack_next;
  logic wr_en;
  logic [7:0] wr_idx, wr_data;
  logic [7:0] hi_lim_reg [NUM_CH];
  logic [7:0] hi_lim_next [NUM_CH];
  logic [7:0] lo_lim_reg [NUM_CH];
  logic [7:0] lo_lim_next [NUM_CH];
  logic [6:0] slave_addr_reg, slave_addr_next;
  logic [1:0] bank_reg, bank_next;
  logic [7:0] i2c_rdata_reg;
  logic [11:0] oor, status_reg;
  logic over_temp, warn_reg, over_temp_reg;

  assign base = {monitor_base_high, monitor_base_low};
  assign idx_hit = (io_addr == base + IDX_PORT_OFS);
  assign data_hit = (io_addr == base + DATA_PORT_OFS);

  function automatic logic [7:0] read_value(input logic [7:0] idx);
    logic [7:0] ofs;
    logic [7:0] hofs;
    logic [7:0] lofs;
    ofs = idx - REG_VOLT_BASE;
    hofs = idx - REG_HI_LIM_BASE;
    lofs = idx - REG_LO_LIM_BASE;
    read_value = 8'h00;
    if (idx >= REG_VOLT_BASE && idx <= REG_VOLT_LAST) begin
      read_value = reading_reg[ofs[3:0]];
    end else if (idx == REG_SYS_TEMP) begin
      read_value = reading_reg[CH_SYS_TEMP];
    end else if (idx >= REG_VOLT_HIGH_BASE && idx <= REG_VOLT_HIGH_LAST) begin
      read_value = reading_reg[VOLT_HIGH_CH + 4'(idx - REG_VOLT_HIGH_BASE)];
    end else if (hofs < 8'(NUM_CH)) begin
      read_value = hi_lim_reg[hofs[3:0]];
    end else if (lofs < 8'(NUM_CH)) begin
      read_value = lo_lim_reg[lofs[3:0]];
    end else if (idx == REG_SLAVE_ADDR) begin
      read_value = {1'b0, slave_addr_reg};
    end else if (idx == REG_STATUS_LO) begin
      read_value = status_reg[7:0];
    end else if (idx == REG_STATUS_HI) begin
      read_value = {4'h0, status_reg[11:8]};
    end else if (idx == REG_BANK_SEL) begin
      read_value = {6'h00, bank_reg};
    end else if (idx == REG_BANK_TEMP_HI) begin
      if (bank_reg == BANK_CPU) begin
        read_value = reading_reg[CH_CPU_TEMP];
      end else if (bank_reg == BANK_AUX) begin
        read_value = reading_reg[CH_AUX_TEMP];
      end
    end else if (idx == REG_BANK_TEMP_LO) begin
      if (bank_reg == BANK_CPU) begin
        read_value[TEMP_LSB_BIT] = cpu_lsb_reg;
      end else if (bank_reg == BANK_AUX) begin
        read_value[TEMP_LSB_BIT] = aux_lsb_reg;
      end
    end
  endfunction : read_value

  // the parallel port wins a same-cycle write; the serial write is dropped
  always_comb begin
    wr_en = 1'b0;
    wr_idx = 8'h00;
    wr_data = 8'h00;
    if (io_wr && data_hit) begin
      wr_en = 1'b1;
      wr_idx = lpc_index_reg;
      wr_data = io_wdata;
    end else if (acc.wr) begin
      wr_en = 1'b1;
      wr_idx = acc.idx;
      wr_data = acc.wdata;
    end
  end

  always_comb begin
    logic [7:0] hofs;
    logic [7:0] lofs;
    hofs = wr_idx - REG_HI_LIM_BASE;
    lofs = wr_idx - REG_LO_LIM_BASE;
    hi_lim_next = hi_lim_reg;
    lo_lim_next = lo_lim_reg;
    slave_addr_next = slave_addr_reg;
    bank_next = bank_reg;
    lpc_index_next = lpc_index_reg;
    io_rdata_next = io_rdata_reg;
    io_ack_next = 1'b0;
    if (io_wr && idx_hit) begin
      lpc_index_next = io_wdata;
    end
    if ((io_wr || io_rd) && (idx_hit || data_hit)) begin
      io_ack_next = 1'b1;
    end
    if (io_rd && idx_hit) begin
      io_rdata_next = lpc_index_reg;
    end else if (io_rd && data_hit) begin
      io_rdata_next = read_value(lpc_index_reg);
    end
    if (wr_en) begin
      if (hofs < 8'(NUM_CH)) begin
        hi_lim_next[hofs[3:0]] = wr_data;
      end else if (lofs < 8'(NUM_CH)) begin
        lo_lim_next[lofs[3:0]] = wr_data;
      end else if (wr_idx == REG_SLAVE_ADDR) begin
        slave_addr_next = wr_data[6:0];
      end else if (wr_idx == REG_BANK_SEL) begin
        bank_next = wr_data[1:0];
      end
    end
  end

  // temperature channels compare signed, voltages unsigned
  always_comb begin
    oor = 12'h000;
    over_temp = 1'b0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (i < NUM_VOLT) begin
        oor[i] = (reading_reg[i] > hi_lim_reg[i]) || (reading_reg[i] < lo_lim_reg[i]);
      end else begin
        oor[i] = ($signed(reading_reg[i]) > $signed(hi_lim_reg[i]))
               || ($signed(reading_reg[i]) < $signed(lo_lim_reg[i]));
        over_temp = over_temp || ($signed(reading_reg[i]) > $signed(hi_lim_reg[i]));
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lpc_index_reg <= 8'h00;
      io_rdata_reg <= 8'h00;
      io_ack_reg <= 1'b0;
      slave_addr_reg <= SLAVE_ADDR_RST;
      bank_reg <= BANK_RST;
      i2c_rdata_reg <= 8'h00;
      status_reg <= 12'h000;
      warn_reg <= 1'b0;
      over_temp_reg <= 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
        hi_lim_reg[i] <= (i < NUM_VOLT) ? VOLT_HI_RST : TEMP_HI_RST;
        lo_lim_reg[i] <= (i < NUM_VOLT) ? VOLT_LO_RST : TEMP_LO_RST;
      end
    end else begin
      lpc_index_reg <= lpc_index_next;
      io_rdata_reg <= io_rdata_next;
      io_ack_reg <= io_ack_next;
      slave_addr_reg <= slave_addr_next;
      bank_reg <= bank_next;
      i2c_rdata_reg <= read_value(acc.idx);
      status_reg <= oor;
      warn_reg <= |oor;
      over_temp_reg <= over_temp;
      hi_lim_reg <= hi_lim_next;
      lo_lim_reg <= lo_lim_next;
    end
  end

  assign acc.rdata = i2c_rdata_reg;
  assign acc.slave_addr = slave_addr_reg;
  assign io_rdata = io_rdata_reg;
  assign io_ack = io_ack_reg;
  assign warning_out = warn_reg;
  assign over_temperature_out = over_temp_reg;
endmodule : hwm_monitor_top

/* File: core/hwm_pkg.sv */
package hwm_pkg;
  // port decode offsets from the programmable 16-bit base
  localparam logic [15:0] IDX_PORT_OFS = 16'h0005;
  localparam logic [15:0] DATA_PORT_OFS = 16'h0006;
  // monitor register indices
  localparam logic [7:0] REG_VOLT_BASE = 8'h20;
  localparam logic [7:0] REG_VOLT_LAST = 8'h26;
  localparam logic [7:0] REG_SYS_TEMP = 8'h27;
  localparam logic [7:0] REG_VOLT_HIGH_BASE = 8'h28;
  localparam logic [7:0] REG_VOLT_HIGH_LAST = 8'h29;
  localparam logic [7:0] REG_HI_LIM_BASE = 8'h30;
  localparam logic [7:0] REG_LO_LIM_BASE = 8'h3C;
  localparam logic [7:0] REG_SLAVE_ADDR = 8'h48;
  localparam logic [7:0] REG_STATUS_LO = 8'h4A;
  localparam logic [7:0] REG_STATUS_HI = 8'h4B;
  localparam logic [7:0] REG_BANK_SEL = 8'h4E;
  localparam logic [7:0] REG_BANK_TEMP_HI = 8'h50;
  localparam logic [7:0] REG_BANK_TEMP_LO = 8'h51;
  localparam int TEMP_LSB_BIT = 7;
  // channel plan: 0..8 voltages, 9 system, 10 processor, 11 auxiliary temperature
  localparam int NUM_CH = 12;
  localparam int NUM_VOLT = 9;
  localparam logic [3:0] CH_SYS_TEMP = 4'h9;
  localparam logic [3:0] CH_CPU_TEMP = 4'hA;
  localparam logic [3:0] CH_AUX_TEMP = 4'hB;
  localparam logic [3:0] LAST_CH = 4'hB;
  localparam logic [3:0] VOLT_HIGH_CH = 4'h7;
  // channels 1..3 are the 3.3 V supplies seen through the halving divider
  localparam logic [11:0] HALVE_MASK = 12'h00E;
  localparam int LSB_MV = 8;
  localparam int FULL_SCALE_MV = 2048;
  // bank codes
  localparam logic [1:0] BANK_CPU = 2'h1;
  localparam logic [1:0] BANK_AUX = 2'h2;
  // reset values; the slave address value is arbitrary
  localparam logic [6:0] SLAVE_ADDR_RST = 7'h2D;
  localparam logic [1:0] BANK_RST = 2'h0;
  localparam logic [7:0] VOLT_HI_RST = 8'hFF;
  localparam logic [7:0] VOLT_LO_RST = 8'h00;
  localparam logic [7:0] TEMP_HI_RST = 8'h7F;
  localparam logic [7:0] TEMP_LO_RST = 8'h80;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [0:0] {SEQ_START, SEQ_WAIT} hwm_seq_t;
  typedef enum logic [3:0] {
    I2C_IDLE, I2C_ADDR, I2C_ADDR_ACK, I2C_IDX, I2C_IDX_ACK,
    I2C_WDATA, I2C_WDATA_ACK, I2C_TX, I2C_TX_ACK
  } hwm_i2c_state_t;
endpackage : hwm_pkg

/* File: testbench/hwm_adc_model.sv */
`timescale 1ns/100ps
module hwm_adc_model (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic adc_start,
  input wire logic [3:0] adc_chan,
  input wire logic slow,
  input wire logic [7:0] code_base,
  output logic adc_done,
  output logic [7:0] adc_data,
  output logic adc_lsb
);
  int cnt = 0;
  logic [3:0] chan = 4'h0;
  // outside the done pulse the result lines toggle so stale data is never usable
  always @(posedge ref_clk) begin
    if (reset) begin
      cnt <= 0;
      adc_done <= 1'b0;
      adc_data <= 8'h00;
      adc_lsb <= 1'b0;
    end else if (cnt == 1 && !adc_start) begin
      cnt <= 0;
      adc_done <= 1'b1;
      adc_data <= code_base + {4'h0, chan};
      adc_lsb <= chan[0];
    end else begin
      adc_done <= 1'b0;
      adc_data <= ~adc_data;
      adc_lsb <= ~adc_lsb;
      if (adc_start) begin
        chan <= adc_chan;
        cnt <= slow ? 9 : 1;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : hwm_adc_model

/* File: testbench/hwm_monitor_assertions.sv */
`timescale 1ns/100ps
module hwm_monitor_checker
  import hwm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] monitor_base_high,
  input wire logic [7:0] monitor_base_low,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_rdata,
  input wire logic io_ack,
  input wire logic sda_out,
  input wire logic scl_in,
  input wire logic sda_oe,
  input wire logic adc_start,
  input wire logic [3:0] adc_chan,
  input wire logic adc_halve,
  input wire logic adc_done,
  input wire logic warning_out,
  input wire logic over_temperature_out
);
  logic [15:0] base;
  logic hit;
  logic [3:0] chan_reg;
  logic [3:0] chan_next;
  assign base = {monitor_base_high, monitor_base_low};
  assign hit = (io_addr == base + IDX_PORT_OFS) || (io_addr == base + DATA_PORT_OFS);
  // expected channel of the next conversion start
  always_comb begin
    chan_next = chan_reg;
    if (adc_start) begin
      chan_next = (adc_chan == LAST_CH) ? 4'h0 : adc_chan + 4'h1;
    end
  end
  always_ff @(posedge ref_clk) begin
    chan_reg <= reset ? 4'h0 : chan_next;
  end
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_ack_on_decode: assert property ((io_wr || io_rd) && hit |=> io_ack)
    else $error("no ack on a decoded port");
  a_no_stray_ack: assert property (!((io_wr || io_rd) && hit) |=> !io_ack)
    else $error("ack without a decoded access");
  a_rdata_holds: assert property (!(io_rd && hit) |=> $stable(io_rdata))
    else $error("read data moved without a read");
  a_halve_chan: assert property (adc_halve == (adc_chan != 4'h0 && adc_chan < 4'h4))
    else $error("divider select wrong for channel");
  a_start_after_done: assert property (adc_done |-> ##2 adc_start)
    else $error("next conversion not started");
  a_chan_order: assert property (adc_start |-> adc_chan == chan_reg)
    else $error("channel out of round robin order");
  a_start_pulse: assert property (adc_start |=> !adc_start)
    else $error("start longer than one cycle");
  a_sda_open_drain: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_ack_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data pull changed while serial clock high");
  a_overtemp_warns: assert property (over_temperature_out |-> warning_out)
    else $error("over temperature without warning");
endmodule : hwm_monitor_checker

/* File: testbench/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import hwm_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] monitor_base_high = 8'h00;
  logic [7:0] monitor_base_low = 8'h00;
  logic [15:0] io_addr = 16'h0000;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] io_rdata;
  logic io_ack;
  logic m_scl = 1'b1;
  logic m_sda = 1'b1;
  logic sda_in;
  logic sda_oe;
  logic adc_start;
  logic [3:0] adc_chan;
  logic adc_done;
  logic [7:0] adc_data;
  logic adc_lsb;
  logic warning_out;
  logic over_temperature_out;
  logic slow = 1'b0;
  logic [7:0] code_base = 8'h20;
  logic [15:0] base = 16'h0290;
  logic [15:0] rnd = 16'h0003;
  logic [7:0] v;
  logic [6:0] sa;
  int bad_count = 0;
  int num_checks = 0;

  always #4 ref_clk = ~ref_clk;
  // open-drain line: low while either side pulls
  assign sda_in = m_sda & ~sda_oe;

  hwm_monitor_top hwm_monitor_top_i (
    .ref_clk(ref_clk), .reset(reset), .monitor_base_high(monitor_base_high),
    .monitor_base_low(monitor_base_low), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_ack(io_ack), .scl_in(m_scl),
    .sda_in(sda_in), .sda_out(), .sda_oe(sda_oe), .adc_start(adc_start),
    .adc_chan(adc_chan), .adc_halve(), .adc_done(adc_done), .adc_data(adc_data),
    .adc_lsb(adc_lsb), .warning_out(warning_out),
    .over_temperature_out(over_temperature_out)
  );
  hwm_adc_model hwm_adc_model_i (
    .ref_clk(ref_clk), .reset(reset), .adc_start(adc_start), .adc_chan(adc_chan),
    .slow(slow), .code_base(code_base), .adc_done(adc_done), .adc_data(adc_data),
    .adc_lsb(adc_lsb)
  );

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [7:0] exp_code(input logic [3:0] ch);
    return code_base + {4'h0, ch};
  endfunction : exp_code
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  task automatic io_cycle(input logic [15:0] a, input logic w, input logic [7:0] d,
                          input logic ack);
    @(posedge ref_clk);
    io_addr <= a;
    io_wr <= w;
    io_rd <= ~w;
    io_wdata <= d;
    @(posedge ref_clk);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    #1;
    check({7'h0, io_ack}, {7'h0, ack}, "port ack");
  endtask : io_cycle
  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
    io_cycle(base + IDX_PORT_OFS, 1'b1, idx, 1'b1);
    io_cycle(base + DATA_PORT_OFS, 1'b1, d, 1'b1);
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] idx, output logic [7:0] d);
    io_cycle(base + IDX_PORT_OFS, 1'b1, idx, 1'b1);
    io_cycle(base + DATA_PORT_OFS, 1'b0, 8'h00, 1'b1);
    d = io_rdata;
  endtask : reg_rd
  // two wraps of the last channel guarantee every reading was refreshed
  task automatic wait_refresh();
    int k;
    k = 0;
    repeat (2) begin
      do begin
        @(negedge ref_clk);
        k++;
      end while (!(adc_done && adc_chan == LAST_CH) && k < 4000);
    end
    repeat (4) @(negedge ref_clk);
    if (k >= 4000) begin
      bad_count++;
      $display("wrong value at %0t: no conversion round", $time);
    end
  endtask : wait_refresh
  task automatic sclk(input logic s, input logic d);
    @(posedge ref_clk);
    m_scl <= s;
    m_sda <= d;
    repeat (7) @(posedge ref_clk);
  endtask : sclk
  task automatic i2c_byte(input logic [7:0] b, input logic nack);
    logic ack;
    for (int i = 7; i >= 0; i--) begin
      sclk(1'b0, b[i]);
      sclk(1'b1, b[i]);
      sclk(1'b0, b[i]);
    end
    sclk(1'b0, 1'b1);
    sclk(1'b1, 1'b1);
    ack = sda_in;
    sclk(1'b0, 1'b1);
    check({7'h0, ack}, {7'h0, nack}, "serial ack");
  endtask : i2c_byte
  task automatic i2c_frame(input logic [6:0] a, input logic [7:0] i, input logic [7:0] d);
    sclk(1'b1, 1'b1);
    sclk(1'b1, 1'b0);
    i2c_byte({a, 1'b0}, a != sa);
    if (a == sa) begin
      i2c_byte(i, 1'b0);
      i2c_byte(d, 1'b0);
    end
    sclk(1'b0, 1'b0);
    sclk(1'b1, 1'b0);
    sclk(1'b1, 1'b1);
  endtask : i2c_frame
  // read one byte at the last written index, then refuse more and stop
  task automatic i2c_read(input logic [6:0] a, output logic [7:0] d);
    sclk(1'b1, 1'b1);
    sclk(1'b1, 1'b0);
    i2c_byte({a, 1'b1}, 1'b0);
    for (int i = 7; i >= 0; i--) begin
      sclk(1'b0, 1'b1);
      sclk(1'b1, 1'b1);
      d[i] = sda_in;
      sclk(1'b0, 1'b1);
    end
    sclk(1'b0, 1'b1);
    sclk(1'b1, 1'b1);
    sclk(1'b0, 1'b0);
    sclk(1'b1, 1'b0);
    sclk(1'b1, 1'b1);
  endtask : i2c_read

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    bad_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    complete_run();
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      rnd = lfsr(rnd);
      monitor_base_high <= base[15:8];
      monitor_base_low <= base[7:0];
      code_base <= {3'b001, rnd[4:0]};
      slow <= rnd[5] ^ p[0];
      wait_refresh();
      check({7'h0, warning_out}, 8'h00, "idle warning");
      reg_rd(REG_SYS_TEMP, v);
      check(v, exp_code(CH_SYS_TEMP), "system temp");
      reg_rd(REG_VOLT_BASE, v);
      check(v, exp_code(4'h0), "voltage ch0");
      reg_rd(REG_VOLT_HIGH_BASE, v);
      check(v, exp_code(VOLT_HIGH_CH), "voltage ch7");
      for (int b = 1; b < 3; b++) begin
        reg_wr(REG_BANK_SEL, b[7:0]);
        reg_rd(REG_BANK_TEMP_HI, v);
        check(v, exp_code(CH_SYS_TEMP + b[3:0]), "bank high");
        reg_rd(REG_BANK_TEMP_LO, v);
        check({7'h0, v[TEMP_LSB_BIT]}, {7'h0, b == 2}, "bank lsb");
      end
      io_cycle(base + 16'h0007, 1'b0, 8'h00, 1'b0);
      check({7'h0, io_ack}, 8'h00, "stray ack");
      check(io_rdata, v, "held data");
      sa = rnd[14:8];
      reg_wr(REG_SLAVE_ADDR, {1'b0, sa});
      reg_rd(REG_SLAVE_ADDR, v);
      check(v, {1'b0, sa}, "slave address");
      i2c_frame(sa, REG_HI_LIM_BASE, code_base);
      reg_rd(REG_HI_LIM_BASE, v);
      check(v, code_base, "serial write");
      i2c_read(sa, v);
      check(v, code_base, "serial read");
      i2c_frame(sa ^ 7'h01, REG_HI_LIM_BASE, 8'h00);
      reg_wr(REG_HI_LIM_BASE, code_base - 8'h01);
      wait_refresh();
      check({7'h0, warning_out}, 8'h01, "warning");
      check({7'h0, over_temperature_out}, 8'h00, "no over temp");
      reg_rd(REG_STATUS_LO, v);
      check({7'h0, v[0]}, 8'h01, "status ch0");
      reg_wr(REG_HI_LIM_BASE + 8'h09, 8'h00);
      wait_refresh();
      check({7'h0, over_temperature_out}, 8'h01, "over temp");
      reg_wr(REG_HI_LIM_BASE, VOLT_HI_RST);
      reg_wr(REG_HI_LIM_BASE + 8'h09, TEMP_HI_RST);
      wait_refresh();
      check({7'h0, warning_out}, 8'h00, "warning clear");
      $display("test pass %0d done", p);
      base = lfsr(rnd);
    end
    complete_run();
  end
endmodule : testbench

bind hwm_monitor_top hwm_monitor_checker hwm_monitor_checker_i (
  .ref_clk(ref_clk), .reset(reset), .monitor_base_high(monitor_base_high),
  .monitor_base_low(monitor_base_low), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
  .io_rdata(io_rdata), .io_ack(io_ack), .sda_out(sda_out), .scl_in(scl_in),
  .sda_oe(sda_oe), .adc_start(adc_start),
  .adc_chan(adc_chan), .adc_halve(adc_halve), .adc_done(adc_done),
  .warning_out(warning_out), .over_temperature_out(over_temperature_out)
);
